// File: include/scan_status_pkg.sv
// constants, field layout and timing of the scan status relay bank
// assumes a 250 MHz system clock and a scan-end strobe from the sequencer
//
// Notes on behaviour
// - scan toggle bit inverts at every scan end, alternating per scan.
// - on-type first-scan pulse is high only in first scan after run entry.
// - off-type first-scan pulse is low in first run scan, high afterwards.
// - step process pulse is high only in first scan of an activated process.
// - free-running clock bits with 0.01 s and 0.02 s periods.
// - free-running clock bits with 0.1 s and 0.2 s periods.
// - free-running clock bits with 1 s, 2 s and 1 min periods.
// - run-mode status follows the mode selector: high in run, low in edit.
// - message-active bit is high while the message instruction executes.
// - forcing-active bit is high while any contact is being forced.
// - interrupt-enabled bit is high while external interrupts are enabled.
// - interrupt-error bit is set when an interrupt error is detected.
// - sample source bit is 0 for instruction sampling, 1 for timed sampling.
// - trace-end bit sets when sampling stops, clears when sampling starts.
// - stop-trigger bit is 1 while the stop trigger is active, else 0.

package scan_status_pkg;

  // register port
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam logic [1:0] ADDR_TIMING = 2'h0;
  localparam logic [1:0] ADDR_MODE = 2'h1;
  localparam logic [1:0] ADDR_CTRL = 2'h2;

  // timing word bit positions
  localparam int B_ALWAYS_ON = 0;
  localparam int B_ALWAYS_OFF = 1;
  localparam int B_SCAN_TOGGLE = 2;
  localparam int B_FIRST_ON = 3;
  localparam int B_FIRST_OFF = 4;
  localparam int B_STEP_FIRST = 5;
  localparam int B_CLK_10MS = 8;
  localparam int B_CLK_20MS = 9;
  localparam int B_CLK_100MS = 10;
  localparam int B_CLK_200MS = 11;
  localparam int B_CLK_1S = 12;
  localparam int B_CLK_2S = 13;
  localparam int B_CLK_1MIN = 14;

  // mode and trace word bit positions
  localparam int B_RUN_MODE = 0;
  localparam int B_MSG_ACTIVE = 6;
  localparam int B_FORCING = 9;
  localparam int B_INT_EN = 10;
  localparam int B_INT_ERR = 11;
  localparam int B_SAMP_SRC = 12;
  localparam int B_TRACE_END = 13;
  localparam int B_STOP_TRIG = 14;
  localparam int B_SAMP_EN = 15;

  // control word bit positions
  localparam int B_CLR_INT_ERR = 0;

  // reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic RELAY_ON = 1'b1;
  localparam logic RELAY_OFF = 1'b0;

  // time base
  localparam int CLK_MHZ = 250;
  localparam int TIME_BASE_US = 1000;
  localparam int TICK_CYCLES = TIME_BASE_US * CLK_MHZ;
  localparam int TICK_W = 18;
  localparam int HALF_W = 16;

  // clock pulse periods in milliseconds
  localparam int PER_10MS_MS = 10;
  localparam int PER_20MS_MS = 20;
  localparam int PER_100MS_MS = 100;
  localparam int PER_200MS_MS = 200;
  localparam int PER_1S_MS = 1000;
  localparam int PER_2S_MS = 2000;
  localparam int PER_1MIN_MS = 60000;
  localparam int US_PER_MS = 1000;

  // half period in time-base ticks
  function automatic int half_ticks(input int per_ms);
    half_ticks = (per_ms * US_PER_MS) / (TIME_BASE_US * 2);
  endfunction : half_ticks

  // run phase states
  typedef enum logic [1:0] {
    ST_EDIT = 2'b00,
    ST_FIRST = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

endpackage : scan_status_pkg

// File: verilog/clock_pulse_gen.sv
// one free-running square wave clocked by the time-base tick
// assumes tick is a one-cycle strobe on the same clock
`timescale 1ns/1ps
`default_nettype none

module clock_pulse_gen #(
  parameter int unsigned HALF_TICKS = 5
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // time base
  input wire logic tick,
  // square wave
  output logic pulse
);

  localparam int HW = scan_status_pkg::HALF_W;

  typedef logic [HW-1:0] half_cnt_t;

  typedef struct packed {
    half_cnt_t cnt;
    logic level;
  } pulse_state_t;

  pulse_state_t s_q;
  pulse_state_t s_d;

  // toggle after each half period of ticks
  always_comb begin
    s_d = s_q;
    if (tick) begin
      if (s_q.cnt == half_cnt_t'(HALF_TICKS - 1)) begin
        s_d.cnt = '0;
        s_d.level = ~s_q.level;
      end else begin
        s_d.cnt = s_q.cnt + half_cnt_t'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse = s_q.level;

endmodule : clock_pulse_gen

`default_nettype wire

// File: verilog/scan_status_relay_bank.sv
// read-only bank of system status relays for a scan-based controller
// assumes SCAN_END and status inputs come from logic on CLOCK;
// the mode selector arrives from a pin and is synchronised here
// the control word takes software clears; the relay words are read only
`timescale 1ns/1ps
`default_nettype none

module scan_status_relay_bank #(
  parameter int unsigned TICK_CYCLES = scan_status_pkg::TICK_CYCLES,
  parameter int unsigned HALF_10MS =
    scan_status_pkg::half_ticks(scan_status_pkg::PER_10MS_MS),
  parameter int unsigned HALF_20MS =
    scan_status_pkg::half_ticks(scan_status_pkg::PER_20MS_MS),
  parameter int unsigned HALF_100MS =
    scan_status_pkg::half_ticks(scan_status_pkg::PER_100MS_MS),
  parameter int unsigned HALF_200MS =
    scan_status_pkg::half_ticks(scan_status_pkg::PER_200MS_MS),
  parameter int unsigned HALF_1S =
    scan_status_pkg::half_ticks(scan_status_pkg::PER_1S_MS),
  parameter int unsigned HALF_2S =
    scan_status_pkg::half_ticks(scan_status_pkg::PER_2S_MS),
  parameter int unsigned HALF_1MIN =
    scan_status_pkg::half_ticks(scan_status_pkg::PER_1MIN_MS)
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // register port
  input wire logic [scan_status_pkg::ADDR_W-1:0] ADDR,
  input wire logic [scan_status_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [scan_status_pkg::DATA_W-1:0] RDATA,
  // scan sequencer
  input wire logic SCAN_END,
  input wire logic STEP_ACTIVATE,
  // mode selector pin, high in run position
  input wire logic MODE_RUN_PIN,
  // instruction and debug status
  input wire logic MSG_EXECUTING,
  input wire logic FORCING,
  input wire logic INT_ENABLED,
  input wire logic INT_ERROR_EVENT,
  // sample trace
  input wire logic SAMPLE_BY_TIME,
  input wire logic SAMPLE_START,
  input wire logic SAMPLE_STOP,
  input wire logic STOP_TRIGGER,
  // relay words seen by the user program
  output logic [scan_status_pkg::DATA_W-1:0] TIMING_WORD,
  output logic [scan_status_pkg::DATA_W-1:0] MODE_WORD
);

  // short names for the package widths
  localparam int TW = scan_status_pkg::TICK_W;
  localparam int DW = scan_status_pkg::DATA_W;

  // field types of the bank state
  typedef logic [TW-1:0] tick_cnt_t;
  typedef logic [DW-1:0] word_t;

  typedef struct packed {
    // mode selector synchroniser
    logic run_meta;
    logic run_sync;
    // scan-driven state
    scan_status_pkg::run_state_t run_st;
    logic toggle;
    logic step_first;
    // sticky and trace flags
    logic int_err;
    logic trace_end;
    logic samp_en;
    // shared time base
    tick_cnt_t tick_cnt;
    logic tick;
    // registered outputs
    word_t rdata;
    word_t timing_word;
    word_t mode_word;
  } bank_state_t;

  // current and next state of the bank
  bank_state_t s_q;
  bank_state_t s_d;

  // clock pulse bits from the dividers
  logic clk_10ms;
  logic clk_20ms;
  logic clk_100ms;
  logic clk_200ms;
  logic clk_1s;
  logic clk_2s;
  logic clk_1min;

  // software write to the control word
  // the relay words are read only, so writes to them fall away
  logic ctrl_wr;
  logic clr_int_err;

  assign ctrl_wr = WR && (ADDR == scan_status_pkg::ADDR_CTRL);
  assign clr_int_err = ctrl_wr && WDATA[scan_status_pkg::B_CLR_INT_ERR];

  // free-running clock pulse generators on the shared time base
  // 10 ms bit
  clock_pulse_gen #(
    .HALF_TICKS(HALF_10MS)
  ) u_clk_10ms (
    .clock(CLOCK),
    .rst_b(RST_B),
    .tick(s_q.tick),
    .pulse(clk_10ms)
  );

  // 20 ms bit
  clock_pulse_gen #(
    .HALF_TICKS(HALF_20MS)
  ) u_clk_20ms (
    .clock(CLOCK),
    .rst_b(RST_B),
    .tick(s_q.tick),
    .pulse(clk_20ms)
  );

  // 100 ms bit
  clock_pulse_gen #(
    .HALF_TICKS(HALF_100MS)
  ) u_clk_100ms (
    .clock(CLOCK),
    .rst_b(RST_B),
    .tick(s_q.tick),
    .pulse(clk_100ms)
  );

  // 200 ms bit
  clock_pulse_gen #(
    .HALF_TICKS(HALF_200MS)
  ) u_clk_200ms (
    .clock(CLOCK),
    .rst_b(RST_B),
    .tick(s_q.tick),
    .pulse(clk_200ms)
  );

  // 1 s bit
  clock_pulse_gen #(
    .HALF_TICKS(HALF_1S)
  ) u_clk_1s (
    .clock(CLOCK),
    .rst_b(RST_B),
    .tick(s_q.tick),
    .pulse(clk_1s)
  );

  // 2 s bit
  clock_pulse_gen #(
    .HALF_TICKS(HALF_2S)
  ) u_clk_2s (
    .clock(CLOCK),
    .rst_b(RST_B),
    .tick(s_q.tick),
    .pulse(clk_2s)
  );

  // 1 min bit
  clock_pulse_gen #(
    .HALF_TICKS(HALF_1MIN)
  ) u_clk_1min (
    .clock(CLOCK),
    .rst_b(RST_B),
    .tick(s_q.tick),
    .pulse(clk_1min)
  );

  // next state of the whole bank
  always_comb begin
    s_d = s_q;

    // two-stage synchroniser for the mode selector pin
    // only run_sync is read; run_meta may be caught mid-change
    s_d.run_meta = MODE_RUN_PIN;
    s_d.run_sync = s_q.run_meta;

    // time-base tick, one cycle every TICK_CYCLES clocks
    // one shared counter keeps every clock bit in step
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == tick_cnt_t'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + tick_cnt_t'(1);
    end

    // scan toggle inverts at each scan end
    // SCAN_END is a one-cycle strobe from the scan sequencer
    if (SCAN_END) begin
      s_d.toggle = ~s_q.toggle;
    end

    // run phase: first scan after run entry, then running
    // the selector leaving run drops back to edit from any state
    case (s_q.run_st)
      // program edit: both first-scan pulse bits low
      scan_status_pkg::ST_EDIT: begin
        if (s_q.run_sync) begin
          s_d.run_st = scan_status_pkg::ST_FIRST;
        end
      end
      // first run scan: on pulse high until the scan ends
      scan_status_pkg::ST_FIRST: begin
        if (!s_q.run_sync) begin
          s_d.run_st = scan_status_pkg::ST_EDIT;
        end else if (SCAN_END) begin
          s_d.run_st = scan_status_pkg::ST_RUN;
        end
      end
      // later run scans: off pulse high while the selector stays in run
      scan_status_pkg::ST_RUN: begin
        if (!s_q.run_sync) begin
          s_d.run_st = scan_status_pkg::ST_EDIT;
        end
      end
      // unused code falls back to edit
      default: begin
        s_d.run_st = scan_status_pkg::ST_EDIT;
      end
    endcase

    // step process pulse lasts to the end of the activating scan
    // STEP_ACTIVATE wins a tie so the pulse spans one whole scan
    if (STEP_ACTIVATE) begin
      s_d.step_first = 1'b1;
    end else if (SCAN_END) begin
      s_d.step_first = 1'b0;
    end

    // interrupt error is sticky; a new error beats a software clear
    // software clears it by writing one to bit0 of the control word
    if (INT_ERROR_EVENT) begin
      s_d.int_err = 1'b1;
    end else if (clr_int_err) begin
      s_d.int_err = 1'b0;
    end

    // trace end and enable move only on the sampling strobes
    // trace end: stop sets, start clears, stop wins on a tie
    if (SAMPLE_STOP) begin
      s_d.trace_end = 1'b1;
    end else if (SAMPLE_START) begin
      s_d.trace_end = 1'b0;
    end

    // sampling enable: start sets, stop clears, stop wins on a tie
    if (SAMPLE_STOP) begin
      s_d.samp_en = 1'b0;
    end else if (SAMPLE_START) begin
      s_d.samp_en = 1'b1;
    end

    // timing relay word, unused bits read as zero
    s_d.timing_word = scan_status_pkg::WORD_RST;

    // fixed relays, independent of mode and scan
    s_d.timing_word[scan_status_pkg::B_ALWAYS_ON] =
      scan_status_pkg::RELAY_ON;
    s_d.timing_word[scan_status_pkg::B_ALWAYS_OFF] =
      scan_status_pkg::RELAY_OFF;

    // scan-driven relays
    s_d.timing_word[scan_status_pkg::B_SCAN_TOGGLE] = s_q.toggle;
    s_d.timing_word[scan_status_pkg::B_FIRST_ON] =
      (s_q.run_st == scan_status_pkg::ST_FIRST);
    s_d.timing_word[scan_status_pkg::B_FIRST_OFF] =
      (s_q.run_st == scan_status_pkg::ST_RUN);
    s_d.timing_word[scan_status_pkg::B_STEP_FIRST] = s_q.step_first;

    // free-running clock relays, unaffected by mode
    s_d.timing_word[scan_status_pkg::B_CLK_10MS] = clk_10ms;
    s_d.timing_word[scan_status_pkg::B_CLK_20MS] = clk_20ms;
    s_d.timing_word[scan_status_pkg::B_CLK_100MS] = clk_100ms;
    s_d.timing_word[scan_status_pkg::B_CLK_200MS] = clk_200ms;
    s_d.timing_word[scan_status_pkg::B_CLK_1S] = clk_1s;
    s_d.timing_word[scan_status_pkg::B_CLK_2S] = clk_2s;
    s_d.timing_word[scan_status_pkg::B_CLK_1MIN] = clk_1min;

    // mode and trace relay word, unused bits read as zero
    s_d.mode_word = scan_status_pkg::WORD_RST;

    // synchronised mode selector
    s_d.mode_word[scan_status_pkg::B_RUN_MODE] = s_q.run_sync;

    // instruction and debug levels, one cycle behind their inputs
    s_d.mode_word[scan_status_pkg::B_MSG_ACTIVE] = MSG_EXECUTING;
    s_d.mode_word[scan_status_pkg::B_FORCING] = FORCING;
    s_d.mode_word[scan_status_pkg::B_INT_EN] = INT_ENABLED;

    // sticky interrupt error
    s_d.mode_word[scan_status_pkg::B_INT_ERR] = s_q.int_err;

    // sample trace status
    s_d.mode_word[scan_status_pkg::B_SAMP_SRC] = SAMPLE_BY_TIME;
    s_d.mode_word[scan_status_pkg::B_TRACE_END] = s_q.trace_end;
    s_d.mode_word[scan_status_pkg::B_STOP_TRIG] = STOP_TRIGGER;
    s_d.mode_word[scan_status_pkg::B_SAMP_EN] = s_q.samp_en;

    // read data, valid only the cycle after a read strobe
    // no wait states: the answer always comes on the next edge
    s_d.rdata = scan_status_pkg::WORD_RST;
    if (RD) begin
      case (ADDR)
        scan_status_pkg::ADDR_TIMING: begin
          s_d.rdata = s_q.timing_word;
        end
        scan_status_pkg::ADDR_MODE: begin
          s_d.rdata = s_q.mode_word;
        end
        default: begin
          s_d.rdata = scan_status_pkg::WORD_RST; // control and unmapped
        end
      endcase
    end
  end

  // state register; synchronous reset clears every field
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops; read data stands one cycle
  assign RDATA = s_q.rdata;

  // relay words, one cycle behind their sources
  assign TIMING_WORD = s_q.timing_word;
  assign MODE_WORD = s_q.mode_word;

endmodule : scan_status_relay_bank

`default_nettype wire

// File: tb/scan_status_relay_bank_sva.sv
// assertion checker for the scan status relay bank
// assumes it is bound to the bank top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module scan_status_relay_bank_sva #(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned HALF_10MS = 1
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // status inputs
  input wire logic SCAN_END,
  input wire logic STEP_ACTIVATE,
  input wire logic MODE_RUN_PIN,
  input wire logic MSG_EXECUTING,
  input wire logic FORCING,
  input wire logic INT_ENABLED,
  input wire logic INT_ERROR_EVENT,
  input wire logic SAMPLE_BY_TIME,
  input wire logic SAMPLE_START,
  input wire logic SAMPLE_STOP,
  input wire logic STOP_TRIGGER,
  // relay words
  input wire logic [15:0] TIMING_WORD,
  input wire logic [15:0] MODE_WORD
);
  localparam int H8 = HALF_10MS * TICK_CYCLES;
  logic [2:0] warm_q;
  logic [15:0] c8_q;
  logic l8_q;
  logic seen8_q;
  logic warm;
  logic edge8;
  logic [4:0] lv;

  // warm after four edges out of reset, so $past never sees reset
  assign warm = warm_q[2];
  assign edge8 = TIMING_WORD[8] != l8_q;
  assign lv = {STOP_TRIGGER, SAMPLE_BY_TIME, INT_ENABLED, FORCING,
    MSG_EXECUTING};

  // cycles since reset release and since the last 10 ms bit change
  always_ff @(posedge CLOCK) begin
    l8_q <= TIMING_WORD[8];
    if (!RST_B) begin
      warm_q <= 3'h0;
      c8_q <= 16'h0;
      seen8_q <= 1'b0;
    end else begin
      warm_q <= warm ? warm_q : warm_q + 3'h1;
      c8_q <= edge8 ? 16'h0 : c8_q + 16'h1;
      seen8_q <= seen8_q | edge8;
    end
  end

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  // run entry and the end of the first run scan
  sequence run_entered;
    warm && $rose(MODE_WORD[0]);
  endsequence
  sequence first_scan_ends;
    warm && TIMING_WORD[3] && SCAN_END && MODE_WORD[0];
  endsequence

  chk_const_bits:
    assert property (warm |-> TIMING_WORD[1:0] == 2'h1)
    else $error("constant relay bits wrong");
  chk_scan_toggle:
    assert property (warm |->
      (TIMING_WORD[2] ^ $past(TIMING_WORD[2])) == $past(SCAN_END, 2))
    else $error("scan toggle bit not inverted once per scan");
  chk_run_entry:
    assert property (run_entered |-> ##1 TIMING_WORD[4:3] == 2'h1)
    else $error("first scan pulses wrong at run entry");
  chk_first_end:
    assert property (first_scan_ends |-> ##2 !TIMING_WORD[3])
    else $error("on pulse outlives first scan");
  chk_off_rise:
    assert property (warm && $rose(TIMING_WORD[4]) |-> $past(TIMING_WORD[3]))
    else $error("off pulse rose without a first scan");
  chk_step_pulse:
    assert property (warm && (SCAN_END || STEP_ACTIVATE) |->
      ##2 TIMING_WORD[5] == $past(STEP_ACTIVATE, 2))
    else $error("step first pulse wrong");
  chk_clk_half:
    assert property (warm && seen8_q && edge8 |-> int'(c8_q) == H8 - 1)
    else $error("10 ms clock bit half period wrong");
  chk_run_follow:
    assert property (warm |-> MODE_WORD[0] == $past(MODE_RUN_PIN, 3))
    else $error("run mode bit does not follow selector");
  chk_level_bits:
    assert property (warm |-> {MODE_WORD[14], MODE_WORD[12],
      MODE_WORD[10:9], MODE_WORD[6]} == $past(lv))
    else $error("level status bits wrong");
  chk_int_err_set:
    assert property (warm && INT_ERROR_EVENT |-> ##2 MODE_WORD[11])
    else $error("interrupt error not set");
  chk_trace_stop:
    assert property (warm && SAMPLE_STOP |->
      ##2 MODE_WORD[13] && !MODE_WORD[15])
    else $error("trace stop bits wrong");
  chk_trace_start:
    assert property (warm && SAMPLE_START && !SAMPLE_STOP |->
      ##2 !MODE_WORD[13] && MODE_WORD[15])
    else $error("trace start bits wrong");
endmodule : scan_status_relay_bank_sva

bind scan_status_relay_bank scan_status_relay_bank_sva #(
  .TICK_CYCLES(TICK_CYCLES),
  .HALF_10MS(HALF_10MS)
) u_sva (
  .CLOCK, .RST_B, .SCAN_END, .STEP_ACTIVATE, .MODE_RUN_PIN,
  .MSG_EXECUTING, .FORCING, .INT_ENABLED, .INT_ERROR_EVENT,
  .SAMPLE_BY_TIME, .SAMPLE_START, .SAMPLE_STOP, .STOP_TRIGGER,
  .TIMING_WORD, .MODE_WORD
);

`default_nettype wire

// File: tb/scan_status_relay_bank_tb.sv
// self-checking bench for the scan status relay bank
// assumes a 4-cycle time base so every clock bit turns within 200 cycles
`timescale 1ns/1ps
`default_nettype none

module scan_status_relay_bank_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin = 1'b0;
  logic [4:0] lvl = 5'h0;
  logic [4:0] pls = 5'h0;
  logic [15:0] rdata;
  logic [15:0] tw;
  logic [15:0] mw;
  logic [15:0] m;
  logic t;
  int n_fail = 0;
  int check_count = 0;
  // time base and expected half periods in ticks of bits 8 to 14
  localparam int TB_TICK = 4;
  localparam int H10 =
    scan_status_pkg::half_ticks(scan_status_pkg::PER_10MS_MS);
  localparam int H20 =
    scan_status_pkg::half_ticks(scan_status_pkg::PER_20MS_MS);
  localparam int H100 =
    scan_status_pkg::half_ticks(scan_status_pkg::PER_100MS_MS);
  int half_exp [7] = '{H10, H20, H100, 4, 5, 6, 7};
  int pos [5] = '{6, 9, 10, 12, 14};
  logic [4:0] tp [12] = '{5'h02, 5'h01, 5'h03, 5'h01, 5'h08, 5'h10,
    5'h18, 5'h08, 5'h04, 5'h00, 5'h04, 5'h00};
  logic [15:0] te [12] = '{16'h0020, 16'h0, 16'h0020, 16'h0, 16'h8000,
    16'h2000, 16'h2000, 16'h8000, 16'h0800, 16'h0, 16'h0800, 16'h0};

  // design on a short time base; the fast bits keep their default halves
  scan_status_relay_bank #(.TICK_CYCLES(TB_TICK), .HALF_200MS(4),
    .HALF_1S(5), .HALF_2S(6), .HALF_1MIN(7)) dut (
    .CLOCK(clock), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SCAN_END(pls[0]), .STEP_ACTIVATE(pls[1]),
    .MODE_RUN_PIN(pin), .MSG_EXECUTING(lvl[0]), .FORCING(lvl[1]),
    .INT_ENABLED(lvl[2]), .INT_ERROR_EVENT(pls[2]),
    .SAMPLE_BY_TIME(lvl[3]), .SAMPLE_START(pls[3]), .SAMPLE_STOP(pls[4]),
    .STOP_TRIGGER(lvl[4]), .TIMING_WORD(tw), .MODE_WORD(mw));

  // 250 MHz clock
  always #2 clock = ~clock;

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // wait n edges, then let their updates settle
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // one cycle of optional write beside a set of one-cycle pulses
  task automatic drive(input logic w, input logic [1:0] a,
    input logic [15:0] d, input logic [4:0] p);
    @(posedge clock);
    wr <= w;
    addr <= a;
    wdata <= d;
    pls <= p;
    @(posedge clock);
    wr <= 1'b0;
    pls <= 5'h0;
  endtask : drive

  // read a word and compare its masked bits
  task automatic rx(input logic [1:0] a, input logic [15:0] msk,
    input logic [15:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata & msk, e);
  endtask : rx

  // verdict and end of run
  task automatic final_report();
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // watchdog
  initial begin
    #40000;
    n_fail++;
    final_report();
  end

  // test sequence
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    step(2);
    rx(2'h0, 16'h0003, 16'h0001);
    drive(1'b1, 2'h0, 16'hffff, 5'h0);
    drive(1'b1, 2'h1, 16'hffff, 5'h0);
    rx(2'h0, 16'h0003, 16'h0001);
    rx(2'h1, 16'hffff, 16'h0000);
    rx(2'h3, 16'hffff, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      lvl <= (i < 5) ? 5'(1 << i) : 5'h0;
      step(2);
      m = (i < 5) ? 16'(1 << pos[i]) : 16'h0;
      rx(2'h1, 16'h5640, m);
    end
    @(posedge clock);
    pin <= 1'b1;
    step(5);
    rx(2'h1, 16'h0001, 16'h0001);
    rx(2'h0, 16'h0018, 16'h0008);
    drive(1'b0, 2'h0, 16'h0, 5'h01);
    step(2);
    rx(2'h0, 16'h0018, 16'h0010);
    for (int k = 0; k < 3; k++) begin
      t = tw[2];
      drive(1'b0, 2'h0, 16'h0, 5'h01);
      step(2);
      chk(16'(tw[2]), {15'h0, ~t});
    end
    for (int i = 0; i < 12; i++) begin
      drive(i > 8, 2'h2, 16'h0001, tp[i]);
      step(2);
      m = (i < 4) ? 16'h0020 : (i < 8) ? 16'ha000 : 16'h0800;
      rx((i < 4) ? 2'h0 : 2'h1, m, te[i]);
    end
    @(posedge clock);
    pin <= 1'b0;
    step(5);
    rx(2'h1, 16'h0001, 16'h0000);
    rx(2'h0, 16'h0018, 16'h0000);
    for (int b = 8; b < 15; b++) begin
      logic v;
      int n;
      for (int h = 0; h < 2; h++) begin
        v = tw[b];
        n = 0;
        while (tw[b] === v && n < 1000) begin
          step(1);
          n++;
        end
      end
      chk(16'(n), 16'(TB_TICK * half_exp[b - 8]));
    end
    final_report();
  end
endmodule : scan_status_relay_bank_tb

`default_nettype wire
